// *** design/sppd_strap_ctrl.sv ***
// Power-down strap capture and override for a serial port pair.
// Assumes straps are board tie-offs synchronous enough to clk and that
// the chip reset reaches this block as rst_n, synchronous and active low.
`timescale 1ns/1ps

// What this block does
// RULE1: Pair strap governs power of both the even port and the odd port.
// RULE2: Pair strap sets power state of all four shared transceiver lanes.
// RULE3: Pair strap low powers even port up; odd strap decides odd port.
// RULE4: Pair strap high powers both ports down regardless of odd strap.
// RULE5: Software wide-mode override field replaces sampled pair strap value.
// RULE6: Odd strap low powers odd port up, high powers it down.
// RULE7: In four-lane mode the odd port is unused and kept powered down.
// RULE8: Software narrow-port override field replaces sampled odd strap value.
// RULE9: Board holds straps steady ten clock cycles after reset release.
// RULE10: After capture, strap changes are ignored; only overrides alter power.
// RULE11: Strap pins are inputs normally, driven outputs only in test mode.
// RULE12: Width strap low selects four-lane even port, high two single ports.
// RULE13: Captured straps hold until next reset; overrides take over once written.
module sppd_strap_ctrl #(
   parameter int unsigned HOLD_CYCLES = sppd_pkg::STRAP_HOLD_CYCLES
) (
   // Clock and reset.
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // Strap pins; the two power-down straps split into input, output and output enable, the width strap input only.
   input  wire logic                 pair_powerdown_strap_i,
   output logic                      pair_powerdown_strap_o,
   output logic                      pair_powerdown_strap_oe,
   input  wire logic                 odd_port_powerdown_strap_i,
   output logic                      odd_port_powerdown_strap_o,
   output logic                      odd_port_powerdown_strap_oe,
   input  wire logic                 lane_width_strap,
   // Avalon-MM slave.
   input  wire logic [3:0]           avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [31:0]          avs_writedata,
   input  wire logic [3:0]           avs_byteenable,
   output logic [31:0]               avs_readdata,
   output logic                      avs_waitrequest,
   // Effective power state toward the port power logic.
   output sppd_pkg::sppd_power_s     power_off_control
);

   initial begin
      if (HOLD_CYCLES < 1 || HOLD_CYCLES > 255) begin
         $error("HOLD_CYCLES must lie in 1..255");
      end
   end

   localparam logic [7:0] LAST_CYCLE = 8'(HOLD_CYCLES - 1);

   sppd_pkg::sppd_state_e  state;
   logic [7:0]             hold_count;
   sppd_pkg::sppd_straps_s captured;
   logic [31:0]            loop_reg;
   logic [31:0]            test_reg;
   logic                   ack;
   logic                   test_mode;
   logic                   pair_off_src;
   logic                   odd_off_src;
   logic                   wide_mode;
   logic                   req;
   logic [31:0]            next_loop;
   logic [31:0]            next_test;
   logic [31:0]            bemask;

   // Counts cycles after reset release; straps are taken at the end of the
   // window so that a board that settles late within it is still seen.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state      <= sppd_pkg::SPPD_WAIT;
         hold_count <= 8'h00;
      end else begin
         case (state)
            sppd_pkg::SPPD_WAIT: begin
               if (hold_count == LAST_CYCLE) begin       // see RULE9
                  state <= sppd_pkg::SPPD_DONE;
               end else begin
                  hold_count <= hold_count + 8'h01;
               end
            end
            sppd_pkg::SPPD_DONE: begin
               state <= sppd_pkg::SPPD_DONE;            // see RULE10
            end
            default: begin
               state <= sppd_pkg::SPPD_WAIT;
            end
         endcase
      end
   end

   // Captures the strap levels once; reset gives a constant, the pins are
   // only read by the clocked capture after release.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         captured <= '0;
      end else if (state == sppd_pkg::SPPD_WAIT && hold_count == LAST_CYCLE) begin
         captured.pair_powerdown     <= pair_powerdown_strap_i;     // see RULE13
         captured.odd_port_powerdown <= odd_port_powerdown_strap_i; // see RULE13
         captured.lane_width         <= lane_width_strap;           // see RULE12
      end
   end

   // Byte-enable mask for partial writes.
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         bemask[i*8 +: 8] = {8{avs_byteenable[i]}};
      end
   end

   assign req = avs_read | avs_write;

   // Next values of the writable registers. A write lands only at the edge
   // where waitrequest is low, so a master that holds its request sees it once.
   always_comb begin
      next_loop = loop_reg;
      next_test = test_reg;
      if (avs_write && ack) begin
         if (avs_address == sppd_pkg::ADDR_LOOPBACK_CLKSEL) begin
            next_loop = (loop_reg & ~bemask) | (avs_writedata & bemask & 32'h0000_000F);
         end
         if (avs_address == sppd_pkg::ADDR_TEST_CTRL) begin
            next_test = (test_reg & ~bemask) | (avs_writedata & bemask & 32'h0000_0007);
         end
      end
   end

   // Override register: any write to byte 0 also arms both override enables, so
   // software takes over from both straps with a single write.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         loop_reg <= sppd_pkg::LOOPBACK_RESET;
      end else begin
         loop_reg <= next_loop;                          // see RULE5, RULE8
         if (avs_write && ack && avs_address == sppd_pkg::ADDR_LOOPBACK_CLKSEL
             && avs_byteenable[0]) begin
            loop_reg[sppd_pkg::WIDE_OVR_EN_BIT]   <= 1'b1; // see RULE13
            loop_reg[sppd_pkg::NARROW_OVR_EN_BIT] <= 1'b1; // see RULE13
         end
      end
   end

   // Test control register.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         test_reg <= sppd_pkg::TEST_RESET;
      end else begin
         test_reg <= next_test;
      end
   end

   // One wait cycle per access: waitrequest drops in the cycle after the
   // request is seen, so every access completes in two cycles.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ack <= 1'b0;
      end else begin
         ack <= req && !ack;
      end
   end

   assign avs_waitrequest = req && !ack;

   // Read data is registered and presented in the completing cycle.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && !ack) begin
         case (avs_address)
            sppd_pkg::ADDR_LOOPBACK_CLKSEL: avs_readdata <= loop_reg;
            sppd_pkg::ADDR_TEST_CTRL:       avs_readdata <= test_reg;
            sppd_pkg::ADDR_STRAP_STATUS: begin
               avs_readdata <= 32'h0000_0000;
               avs_readdata[sppd_pkg::ST_PAIR_STRAP_BIT]  <= captured.pair_powerdown;
               avs_readdata[sppd_pkg::ST_ODD_STRAP_BIT]   <= captured.odd_port_powerdown;
               avs_readdata[sppd_pkg::ST_WIDTH_STRAP_BIT] <= captured.lane_width;
               avs_readdata[sppd_pkg::ST_EVEN_OFF_BIT]    <= power_off_control.even_off;
               avs_readdata[sppd_pkg::ST_ODD_OFF_BIT]     <= power_off_control.odd_off;
               avs_readdata[sppd_pkg::ST_WIDE_MODE_BIT]   <= power_off_control.wide_mode;
               avs_readdata[sppd_pkg::ST_CAPTURED_BIT]    <= (state == sppd_pkg::SPPD_DONE);
            end
            default: avs_readdata <= sppd_pkg::UNMAPPED_READ;
         endcase
      end
   end

   // Source of each power-down level: override field once armed, else strap.
   assign pair_off_src = loop_reg[sppd_pkg::WIDE_OVR_EN_BIT] ?
                         loop_reg[sppd_pkg::WIDE_PWR_BIT] :
                         captured.pair_powerdown;          // see RULE5
   assign odd_off_src  = loop_reg[sppd_pkg::NARROW_OVR_EN_BIT] ?
                         loop_reg[sppd_pkg::NARROW_PWR_BIT] :
                         captured.odd_port_powerdown;      // see RULE8
   assign wide_mode    = !captured.lane_width;             // see RULE12

   // Effective power state. Until capture completes the pair is held off,
   // so the port logic never sees a power-up based on unsettled straps.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         power_off_control <= '{even_off: 1'b1, odd_off: 1'b1,
                                lanes_off: 1'b1, wide_mode: 1'b0};
      end else if (state != sppd_pkg::SPPD_DONE) begin
         power_off_control <= '{even_off: 1'b1, odd_off: 1'b1,
                                lanes_off: 1'b1, wide_mode: 1'b0};
      end else begin
         power_off_control.even_off  <= pair_off_src;                  // see RULE1, RULE3
         power_off_control.lanes_off <= pair_off_src;                  // see RULE2
         power_off_control.odd_off   <= pair_off_src | odd_off_src     // see RULE4, RULE6
                                        | wide_mode;                   // see RULE7
         power_off_control.wide_mode <= wide_mode;                     // see RULE12
      end
   end

   // Strap pins drive only in test mode, from the test register.
   assign test_mode = test_reg[sppd_pkg::TEST_MODE_BIT];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pair_powerdown_strap_o      <= 1'b0;
         odd_port_powerdown_strap_o  <= 1'b0;
         pair_powerdown_strap_oe     <= 1'b0;
         odd_port_powerdown_strap_oe <= 1'b0;
      end else begin
         pair_powerdown_strap_o      <= test_reg[sppd_pkg::TEST_PAIR_BIT];
         odd_port_powerdown_strap_o  <= test_reg[sppd_pkg::TEST_ODD_BIT];
         pair_powerdown_strap_oe     <= test_mode;  // see RULE11
         odd_port_powerdown_strap_oe <= test_mode;  // see RULE11
      end
   end

endmodule

// *** design/sppd_pkg.sv ***
// Package for the serial port pair power-down strap block.
// Assumes a 100 MHz core clock and a 32-bit Avalon-MM register bus.
package sppd_pkg;

   // Core clock and strap settle window.
   localparam int unsigned CLK_PERIOD_PS       = 10000;
   localparam int unsigned STRAP_HOLD_CYCLES   = 10;
   // Sampling happens at the last cycle of the hold window.
   localparam int unsigned SAMPLE_CYCLE        = STRAP_HOLD_CYCLES - 1;

   // Register byte addresses (word aligned).
   localparam logic [3:0] ADDR_LOOPBACK_CLKSEL = 4'h0;
   localparam logic [3:0] ADDR_STRAP_STATUS    = 4'h4;
   localparam logic [3:0] ADDR_TEST_CTRL       = 4'h8;

   // Loopback and clock selection register fields.
   localparam int unsigned WIDE_PWR_BIT        = 0;
   localparam int unsigned NARROW_PWR_BIT      = 1;
   localparam int unsigned WIDE_OVR_EN_BIT     = 2;
   localparam int unsigned NARROW_OVR_EN_BIT   = 3;

   // Status register fields.
   localparam int unsigned ST_PAIR_STRAP_BIT   = 0;
   localparam int unsigned ST_ODD_STRAP_BIT    = 1;
   localparam int unsigned ST_WIDTH_STRAP_BIT  = 2;
   localparam int unsigned ST_EVEN_OFF_BIT     = 3;
   localparam int unsigned ST_ODD_OFF_BIT      = 4;
   localparam int unsigned ST_WIDE_MODE_BIT    = 5;
   localparam int unsigned ST_CAPTURED_BIT     = 6;

   // Test control register fields.
   localparam int unsigned TEST_MODE_BIT       = 0;
   localparam int unsigned TEST_PAIR_BIT       = 1;
   localparam int unsigned TEST_ODD_BIT        = 2;

   // Reset values.
   localparam logic [31:0] LOOPBACK_RESET      = 32'h0000_0000;
   localparam logic [31:0] TEST_RESET          = 32'h0000_0000;
   localparam logic [31:0] UNMAPPED_READ       = 32'h0000_0000;

   // Captured strap levels.
   typedef struct packed {
      logic pair_powerdown;
      logic odd_port_powerdown;
      logic lane_width;
   } sppd_straps_s;

   // Effective power state handed to the port power logic.
   typedef struct packed {
      logic even_off;
      logic odd_off;
      logic lanes_off;
      logic wide_mode;
   } sppd_power_s;

   // Capture sequencer states.
   typedef enum logic [1:0] {
      SPPD_WAIT,
      SPPD_DONE
   } sppd_state_e;

endpackage

// *** verif/sppd_board_straps.sv ***
// Board model: tie-off resistors on the two power-down strap pins.
// Assumes the device side comes as split output and output enable.
`timescale 1ns/1ps
module sppd_board_straps (
   // Tie-off levels and mode strap chosen on the board.
   input  wire logic tie_pair,
   input  wire logic tie_odd,
   input  wire logic width,
   // Device side of the two-way pins.
   input  wire logic pair_o,
   input  wire logic pair_oe,
   input  wire logic odd_o,
   input  wire logic odd_oe,
   // Resolved pin levels.
   output logic      pair_lvl,
   output logic      odd_lvl
);
   // A 10K tie-off loses to the pin driver, so a driven level always wins.
   assign pair_lvl = pair_oe ? pair_o : tie_pair;
   // Four-lane boards tie the odd strap high since that port is unused.
   assign odd_lvl = odd_oe ? odd_o : (tie_odd | !width);
endmodule

// *** verif/sppd_checker.sv ***
// Concurrent checks on the strap block ports.
// Assumes binding to the top module with the same hold count.
`timescale 1ns/1ps
module sppd_checker #(
   parameter int unsigned HOLD_CYCLES = 10
) (
   // Clock and reset.
   input wire logic                 clk,
   input wire logic                 rst_n,
   // Strap pins.
   input wire logic                 pair_powerdown_strap_i,
   input wire logic                 odd_port_powerdown_strap_i,
   input wire logic                 lane_width_strap,
   input logic                      pair_powerdown_strap_o,
   input logic                      pair_powerdown_strap_oe,
   input logic                      odd_port_powerdown_strap_oe,
   // Register bus.
   input wire logic [3:0]           avs_address,
   input wire logic                 avs_read,
   input wire logic                 avs_write,
   input wire logic [31:0]          avs_writedata,
   input wire logic [3:0]           avs_byteenable,
   input logic                      avs_waitrequest,
   // Power state.
   input sppd_pkg::sppd_power_s     power_off_control
);
   logic [7:0] cnt;
   logic [2:0] cap;
   logic       ovr;
   logic       lwr;
   logic       twr;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   assign lwr = avs_write && !avs_waitrequest && avs_byteenable[0]
      && avs_address == sppd_pkg::ADDR_LOOPBACK_CLKSEL;
   assign twr = avs_write && !avs_waitrequest && avs_byteenable[0]
      && avs_address == sppd_pkg::ADDR_TEST_CTRL;
   // Edge count since release, straps seen at the sampling edge, override seen.
   always_ff @(posedge clk) begin
      if (!rst_n) cnt <= 8'h00;
      else if (cnt != 8'hFF) cnt <= cnt + 8'h01;
      if (rst_n && cnt == 8'(HOLD_CYCLES - 1))
         cap <= {pair_powerdown_strap_i, odd_port_powerdown_strap_i, lane_width_strap};
      if (!rst_n) ovr <= 1'b0;
      else if (lwr) ovr <= 1'b1;
   end
   sequence s_loop_wr; lwr; endsequence
   sequence s_test_wr;
      avs_write && !avs_waitrequest && avs_byteenable[0]
         && avs_address == sppd_pkg::ADDR_TEST_CTRL;
   endsequence
   sequence s_req; (avs_read || avs_write) && !$past(avs_read || avs_write); endsequence
   property p_hold_off;
      cnt <= HOLD_CYCLES |-> power_off_control == 4'hE;
   endproperty
   a_hold_off: assert property (p_hold_off) else $error("power on before capture");
   property p_even;
      cnt > HOLD_CYCLES && !ovr |-> power_off_control.even_off == cap[2]
         && power_off_control.lanes_off == cap[2];
   endproperty
   a_even: assert property (p_even) else $error("pair power wrong");
   property p_odd;
      cnt > HOLD_CYCLES && !ovr |-> power_off_control.wide_mode == !cap[0]
         && power_off_control.odd_off == (cap[2] | cap[1] | !cap[0]);
   endproperty
   a_odd: assert property (p_odd) else $error("odd power wrong");
   property p_ignore;
      cnt > HOLD_CYCLES && !ovr |=> $stable(power_off_control);
   endproperty
   a_ignore: assert property (p_ignore) else $error("power moved with strap");
   property p_ovr;
      s_loop_wr ##2 1 |-> power_off_control.even_off == $past(avs_writedata[0], 2);
   endproperty
   a_ovr: assert property (p_ovr) else $error("override not applied");
   property p_oe_wr;
      s_test_wr ##2 1 |-> pair_powerdown_strap_oe == $past(avs_writedata[0], 2)
         && odd_port_powerdown_strap_oe == $past(avs_writedata[0], 2)
         && pair_powerdown_strap_o == $past(avs_writedata[1], 2);
   endproperty
   a_oe_wr: assert property (p_oe_wr) else $error("test drive wrong");
   property p_oe_hold;
      $changed(pair_powerdown_strap_oe) |-> $past(twr, 2);
   endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("pin driven outside test");
   property p_bus;
      s_req |-> avs_waitrequest ##1 !avs_waitrequest;
   endproperty
   a_bus: assert property (p_bus) else $error("bus answer timing wrong");
endmodule

// *** verif/sppd_strap_ctrl_tb.sv ***
// Self-checking bench for the strap block with a board tie-off model.
// Assumes the default hold count of the design.
`timescale 1ns/1ps
module sppd_strap_ctrl_tb;
   logic clk = 1'b0, rst_n = 1'b0, tp = 1'b1, to = 1'b1, w = 1'b1, rd = 1'b0, wr = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wd = 32'h0, rdat, q[$];
   logic po, poe, oo, ooe, pl, ol, wq, p, o, x;
   logic [1:0] v;
   sppd_pkg::sppd_power_s pwr;
   int miscompares = 0, checked = 0, seed = 5;
   sppd_strap_ctrl sppd_strap_ctrl_inst (.clk(clk), .rst_n(rst_n),
      .pair_powerdown_strap_i(pl), .pair_powerdown_strap_o(po),
      .pair_powerdown_strap_oe(poe), .odd_port_powerdown_strap_i(ol),
      .odd_port_powerdown_strap_o(oo), .odd_port_powerdown_strap_oe(ooe),
      .lane_width_strap(w), .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat),
      .avs_waitrequest(wq), .power_off_control(pwr));
   sppd_board_straps sppd_board_straps_inst (.tie_pair(tp), .tie_odd(to), .width(w),
      .pair_o(po), .pair_oe(poe), .odd_o(oo), .odd_oe(ooe), .pair_lvl(pl), .odd_lvl(ol));
   // Free-running 100 MHz clock.
   always #5 clk = ~clk;
   task automatic test_done;
      if (miscompares == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   // One bus transfer held until the rising edge that samples waitrequest low.
   task automatic bus(input logic w_n, input logic [3:0] a, input logic [31:0] d, e);
      int n;
      n = 0;
      adr <= a;
      wd <= d;
      wr <= w_n;
      rd <= !w_n;
      if (!w_n) q.push_back(e);
      do begin
         @(posedge clk);
         n++;
      end while (wq !== 1'b0 && n < 50);
      if (wq !== 1'b0) begin
         miscompares++;
         test_done();
      end
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask
   // Read data is compared mid-cycle, where it is settled, against the oldest note.
   always @(negedge clk) begin
      if (rd && wq === 1'b0 && q.size() > 0) chk(rdat, q.pop_front());
   end
   // Every strap combination, then a later strap change, override and test drive.
   initial begin
      @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         {tp, to, w} <= i[2:0];
         rst_n <= 1'b0;
         repeat (3) @(posedge clk);
         rst_n <= 1'b1;
         repeat (12) @(posedge clk);
         {p, o, x} = i[2:0];
         o = o | !x;
         {tp, to} <= ~i[2:1];
         v = 2'($random(seed));
         bus(0, 4'h0, 0, 0);
         bus(0, 4'h4, 0, {25'h1, !x, p | o | !x, p, x, o, p});
         bus(1, 4'h0, {30'h0, v}, 0);
         bus(0, 4'h4, 0, {25'h1, !x, v[0] | v[1] | !x, v[0], x, o, p});
         bus(0, 4'h0, 0, {28'h3, v});
         bus(1, 4'h8, {29'h0, v, 1'b1}, 0);
         @(negedge clk);
         chk({pl, ol, poe, ooe}, {v[0], v[1], 2'h3});
         @(posedge clk);
         bus(0, 4'h8, 0, {29'h0, v, 1'b1});
         bus(1, 4'h8, 0, 0);
         @(negedge clk);
         chk({poe, ooe}, 0);
         @(posedge clk);
         bus(1, 4'hC, 32'hFFFFFFFF, 0);
         bus(0, 4'hC, 0, 0);
      end
      test_done();
   end
endmodule
bind sppd_strap_ctrl sppd_checker #(.HOLD_CYCLES(HOLD_CYCLES)) sppd_checker_inst (
   .clk(clk), .rst_n(rst_n), .pair_powerdown_strap_i(pair_powerdown_strap_i),
   .odd_port_powerdown_strap_i(odd_port_powerdown_strap_i), .lane_width_strap(lane_width_strap),
   .pair_powerdown_strap_o(pair_powerdown_strap_o), .avs_address(avs_address),
   .pair_powerdown_strap_oe(pair_powerdown_strap_oe), .avs_read(avs_read),
   .odd_port_powerdown_strap_oe(odd_port_powerdown_strap_oe), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_waitrequest(avs_waitrequest), .power_off_control(power_off_control));
